/* verilog/pending_query.sv */
/*
 * Highest pending identifier query: decodes core system register reads of
 * the group 0 and group 1 query registers, decides the outcome, answers.
 * Assumes controls and pending identifiers come from same-clock logic.
 */
`timescale 1ns/1ns
`default_nettype none
module pending_query (
	// Clock and reset
	input  wire  logic                   REF_CLK,
	input  wire  logic                   SRST,
	// Core read request
	input  wire  logic                   RD_VALID,
	input  wire  logic [3:0]             RD_COPROC,
	input  wire  logic [2:0]             RD_OPC1,
	input  wire  logic [3:0]             RD_CRN,
	input  wire  logic [3:0]             RD_CRM,
	input  wire  logic [2:0]             RD_OPC2,
	input  wire  logic [1:0]             RD_LEVEL,
	input  wire  logic                   RD_NONSECURE,
	input  wire  logic                   RD_MONITOR_MODE,
	// Controls
	input  wire  logic                   MONITOR_IS_64,
	input  wire  logic                   HYP_FAST_IRQ_ROUTING,
	input  wire  logic                   HYP_NORMAL_IRQ_ROUTING,
	input  wire  logic                   HYP_SYSREG_GROUP12_TRAP,
	input  wire  logic                   LEVEL1_SYSREG_ENABLE,
	input  wire  logic                   LEVEL2_SYSREG_ENABLE,
	input  wire  logic                   LEVEL3_SYSREG_ENABLE,
	input  wire  logic                   TRAP_ALL_GROUP0,
	input  wire  logic                   TRAP_ALL_GROUP1,
	input  wire  logic                   SECURE_FAST_IRQ_ROUTING,
	input  wire  logic                   SECURE_NORMAL_IRQ_ROUTING,
	input  wire  logic                   MONITOR64_FAST_IRQ_ROUTING,
	input  wire  logic                   MONITOR64_NORMAL_IRQ_ROUTING,
	input  wire  logic [2:0]             IDENTIFIER_WIDTH_FIELD,
	// Prioritisation results
	input  wire  logic                   GROUP0_OBSERVABLE,
	input  wire  logic [23:0]            GROUP0_PENDING_ID,
	input  wire  logic [23:0]            GROUP0_SPECIAL_ID,
	input  wire  logic                   GROUP1_OBSERVABLE,
	input  wire  logic [23:0]            GROUP1_PENDING_ID,
	// Answer
	output var   logic                   RD_DONE,
	output var   logic [2:0]             RD_OUTCOME,
	output var   logic [31:0]            RD_DATA
);
	import pending_query_pkg::*;

	// Selected answer, registered next cycle
	logic        hit0;
	logic        hit1;
	logic        ns_l1;
	logic [2:0]  outcome_next;
	logic [31:0] data_next;
	logic        done_reg;
	logic [2:0]  outcome_reg;
	logic [31:0] data_reg;

	// Decode of one query encoding; used for both groups
	function automatic logic enc_match(input logic [3:0] crm);
		enc_match = RD_COPROC == COPROC_SYS && RD_OPC1 == OPC1_QUERY &&
			RD_CRN == CRN_QUERY && RD_CRM == crm && RD_OPC2 == OPC2_QUERY;
	endfunction

	// Width clamp: narrow identifiers read zero in bits 23..16
	function automatic logic [31:0] fit_id(input logic [23:0] id);
		fit_id = {8'h00, id};
		if (IDENTIFIER_WIDTH_FIELD == IDENTIFIER_WIDTH_FIELD_16)
			fit_id[ID_FIELD_MSB:ID_NARROW_BITS] = 8'h00;
	endfunction

	// Only legal special codes leave on group 0; anything else becomes 1023
	function automatic logic [23:0] legal_special0(input logic [23:0] s);
		if (s == SPECIAL_1020 || s == SPECIAL_1021)
			legal_special0 = s;
		else
			legal_special0 = SPECIAL_1023;
	endfunction

	assign hit0  = enc_match(CRM_GROUP0);
	assign hit1  = enc_match(CRM_GROUP1);
	assign ns_l1 = RD_NONSECURE && RD_LEVEL == LEVEL1;

	// Outcome decision; one register for both security states
	always_comb begin
		outcome_next = OUT_DATA;
		data_next    = READ_ZERO;
		if (!(hit0 || hit1)) begin
			outcome_next = OUT_NOT_MINE;
		end else if (RD_LEVEL == LEVEL0) begin
			outcome_next = OUT_UNDEF;
		end else if (ns_l1 && HYP_SYSREG_GROUP12_TRAP) begin
			outcome_next = OUT_TRAP_L2;
		end else if (ns_l1 && hit0 && HYP_FAST_IRQ_ROUTING) begin
			outcome_next = OUT_VIRTUAL;
		end else if (ns_l1 && hit1 && HYP_NORMAL_IRQ_ROUTING) begin
			outcome_next = OUT_VIRTUAL;
		end else if ((RD_LEVEL == LEVEL1 && !LEVEL1_SYSREG_ENABLE) ||
			(RD_LEVEL == LEVEL2 && !LEVEL2_SYSREG_ENABLE) ||
			(RD_LEVEL == LEVEL3 && !LEVEL3_SYSREG_ENABLE)) begin
			outcome_next = OUT_UNDEF;
		end else if (ns_l1 && hit0 && TRAP_ALL_GROUP0) begin
			outcome_next = OUT_TRAP_L2;
		end else if (ns_l1 && hit1 && TRAP_ALL_GROUP1) begin
			outcome_next = OUT_TRAP_L2;
		end else if (hit0 && !MONITOR_IS_64 && SECURE_FAST_IRQ_ROUTING &&
			(RD_LEVEL == LEVEL2 || (RD_LEVEL == LEVEL3 && !RD_MONITOR_MODE) || ns_l1)) begin
			outcome_next = OUT_UNDEF;
		end else if (hit0 && MONITOR_IS_64 && MONITOR64_FAST_IRQ_ROUTING &&
			(RD_LEVEL == LEVEL2 || RD_LEVEL == LEVEL1)) begin
			outcome_next = OUT_TRAP_L3;
		end else if (hit1 && !MONITOR_IS_64 && SECURE_NORMAL_IRQ_ROUTING &&
			(RD_LEVEL == LEVEL2 || (RD_LEVEL == LEVEL3 && !RD_MONITOR_MODE) || ns_l1)) begin
			outcome_next = OUT_UNDEF;
		end else if (hit1 && MONITOR_IS_64 && MONITOR64_NORMAL_IRQ_ROUTING &&
			(RD_LEVEL == LEVEL2 || RD_LEVEL == LEVEL1)) begin
			outcome_next = OUT_TRAP_L3;
		end else if (hit0) begin
			if (GROUP0_OBSERVABLE)
				data_next = fit_id(GROUP0_PENDING_ID);
			else
				data_next = fit_id(legal_special0(GROUP0_SPECIAL_ID));
		end else begin
			if (GROUP1_OBSERVABLE)
				data_next = fit_id(GROUP1_PENDING_ID);
			else
				data_next = fit_id(SPECIAL_1023);
		end
	end

	// Answer registers; reads drive nothing back into interrupt state
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			done_reg    <= 1'b0;
			outcome_reg <= OUT_DATA;
			data_reg    <= READ_ZERO;
		end else begin
			done_reg <= RD_VALID;
			if (RD_VALID) begin
				outcome_reg <= outcome_next;
				data_reg    <= data_next;
			end
		end
	end

	assign RD_DONE    = done_reg;
	assign RD_OUTCOME = outcome_reg;
	assign RD_DATA    = data_reg;
endmodule
`default_nettype wire

/* shared/pending_query_pkg.sv */
/*
 * Constants for the highest pending identifier query block: coprocessor
 * encodings, identifier widths, special identifiers and outcome codes.
 * Assumes a single clock domain and a core-side system register port.
 */
package pending_query_pkg;
	// Coprocessor encoding fields
	localparam logic [3:0] COPROC_SYS      = 4'hF;
	localparam logic [2:0] OPC1_QUERY      = 3'h0;
	localparam logic [3:0] CRN_QUERY       = 4'hC;
	localparam logic [3:0] CRM_GROUP0      = 4'h8;
	localparam logic [3:0] CRM_GROUP1      = 4'hC;
	localparam logic [2:0] OPC2_QUERY      = 3'h2;
	// Identifier field layout
	localparam int         ID_FIELD_MSB    = 23;
	localparam int         ID_NARROW_BITS  = 16;
	localparam int         ID_WIDE_BITS    = 24;
	localparam logic [2:0] IDENTIFIER_WIDTH_FIELD_16       = 3'h0;
	localparam logic [2:0] IDENTIFIER_WIDTH_FIELD_24       = 3'h1;
	// Special identifiers
	localparam logic [23:0] SPECIAL_1020   = 24'h0003FC;
	localparam logic [23:0] SPECIAL_1021   = 24'h0003FD;
	localparam logic [23:0] SPECIAL_1023   = 24'h0003FF;
	// Exception levels
	localparam logic [1:0] LEVEL0          = 2'h0;
	localparam logic [1:0] LEVEL1          = 2'h1;
	localparam logic [1:0] LEVEL2          = 2'h2;
	localparam logic [1:0] LEVEL3          = 2'h3;
	// Read outcome codes
	localparam logic [2:0] OUT_DATA        = 3'h0;
	localparam logic [2:0] OUT_VIRTUAL     = 3'h1;
	localparam logic [2:0] OUT_UNDEF       = 3'h2;
	localparam logic [2:0] OUT_TRAP_L2     = 3'h3;
	localparam logic [2:0] OUT_TRAP_L3     = 3'h4;
	localparam logic [2:0] OUT_NOT_MINE    = 3'h5;
	localparam logic [31:0] READ_ZERO      = 32'h00000000;
endpackage

/* verification/pending_query_sva.sv */
/* Checker for the query block: answer timing, refusals and field masking.
   Bound to the block; sees only its ports. */
`timescale 1ns/1ns
`default_nettype none
module pending_query_sva
	import pending_query_pkg::*;
(
	// Clock, reset and request
	input wire logic        REF_CLK, SRST, RD_VALID, RD_NONSECURE,
	input wire logic [3:0]  RD_COPROC, RD_CRN, RD_CRM,
	input wire logic [2:0]  RD_OPC1, RD_OPC2, IDENTIFIER_WIDTH_FIELD,
	input wire logic [1:0]  RD_LEVEL,
	// Controls and answer
	input wire logic        HYP_SYSREG_GROUP12_TRAP, LEVEL2_SYSREG_ENABLE, RD_DONE,
	input wire logic [2:0]  RD_OUTCOME,
	input wire logic [31:0] RD_DATA
);
	// Either query encoding; CRM bit 2 picks the group
	wire logic hit = RD_VALID && {RD_COPROC, RD_OPC1, RD_CRN, RD_OPC2} == 14'h3C62
		&& RD_CRM[3] && RD_CRM[1:0] == 2'h0;
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (SRST);
	done_next_a: assert property (RD_VALID |=> RD_DONE)
		else $error("read not answered");
	idle_quiet_a: assert property (!RD_VALID |=> !RD_DONE && $stable(RD_DATA))
		else $error("answer without read");
	level0_undef_a: assert property (hit && RD_LEVEL == LEVEL0
		|=> RD_OUTCOME == OUT_UNDEF && RD_DATA == READ_ZERO) else $error("level0 read");
	group12_trap_a: assert property (hit && RD_NONSECURE && RD_LEVEL == LEVEL1
		&& HYP_SYSREG_GROUP12_TRAP |=> RD_OUTCOME == OUT_TRAP_L2) else $error("no trap");
	level2_undef_a: assert property (hit && RD_LEVEL == LEVEL2
		&& !LEVEL2_SYSREG_ENABLE |=> RD_OUTCOME == OUT_UNDEF) else $error("enable ignored");
	unmapped_a: assert property (RD_VALID && !hit |=> RD_OUTCOME == OUT_NOT_MINE)
		else $error("foreign encoding claimed");
	top_zero_a: assert property (RD_DONE |-> RD_DATA[31:24] == 8'h00)
		else $error("upper byte set");
	narrow_a: assert property (RD_DONE && $past(IDENTIFIER_WIDTH_FIELD) == IDENTIFIER_WIDTH_FIELD_16
		|-> RD_DATA[23:16] == 8'h00) else $error("narrow id bits set");
	// Main scenarios reached
	cover property (hit ##1 RD_OUTCOME == OUT_DATA);
	cover property (hit && RD_LEVEL == LEVEL0);
	cover property (RD_VALID [*2]);
endmodule
bind pending_query pending_query_sva chk_u (.*);
`default_nettype wire

/* verification/core_model.sv */
/* Core side model: issues at most one register read per cycle.
   Assumes the bench calls send just after a rising edge. */
`timescale 1ns/1ns
`default_nettype none
module core_model (
	// Request to the query block
	output var logic        RD_VALID,
	output var logic [17:0] ENC
);
	// Idle fields show the inverse so a stale encoding never looks live
	task automatic send(input logic on, input logic [17:0] e);
		RD_VALID = on;
		ENC = on ? e : ~e;
	endtask
endmodule
`default_nettype wire

/* verification/tb_top.sv */
/* Random core reads against the query block, answers checked from a queue.
   Assumes the package constants and a 50 MHz clock. */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import pending_query_pkg::*;
	logic REF_CLK = 0, SRST = 1, ns = 0, mm = 0, o0 = 0, o1 = 0, g, on, m;
	logic [1:0] lv = 0;
	logic [2:0] w = 0;
	logic [12:0] c = 0;
	logic [23:0] p0 = 0, s0 = 0, p1 = 0;
	logic [17:0] e;
	logic [34:0] q[$], x;
	int fail_count = 0, samples_checked = 0, cyc = 0;
	wire logic RD_VALID, RD_DONE;
	wire logic [3:0] cp, crn, crm;
	wire logic [2:0] op1, op2, oc;
	wire logic [31:0] dat;
	core_model core_u (.RD_VALID(RD_VALID), .ENC({cp, op1, crn, crm, op2}));
	pending_query dut_u (.REF_CLK(REF_CLK), .SRST(SRST), .RD_VALID(RD_VALID), .RD_COPROC(cp),
		.RD_OPC1(op1), .RD_CRN(crn), .RD_CRM(crm), .RD_OPC2(op2), .RD_LEVEL(lv),
		.RD_NONSECURE(ns), .RD_MONITOR_MODE(mm), .MONITOR_IS_64(c[0]),
		.HYP_FAST_IRQ_ROUTING(c[1]), .HYP_NORMAL_IRQ_ROUTING(c[2]),
		.HYP_SYSREG_GROUP12_TRAP(c[3]), .LEVEL1_SYSREG_ENABLE(c[4]),
		.LEVEL2_SYSREG_ENABLE(c[5]), .LEVEL3_SYSREG_ENABLE(c[6]), .TRAP_ALL_GROUP0(c[7]),
		.TRAP_ALL_GROUP1(c[8]), .SECURE_FAST_IRQ_ROUTING(c[9]),
		.SECURE_NORMAL_IRQ_ROUTING(c[10]), .MONITOR64_FAST_IRQ_ROUTING(c[11]),
		.MONITOR64_NORMAL_IRQ_ROUTING(c[12]), .IDENTIFIER_WIDTH_FIELD(w),
		.GROUP0_OBSERVABLE(o0), .GROUP0_PENDING_ID(p0), .GROUP0_SPECIAL_ID(s0),
		.GROUP1_OBSERVABLE(o1), .GROUP1_PENDING_ID(p1), .RD_DONE(RD_DONE),
		.RD_OUTCOME(oc), .RD_DATA(dat));
	// Expected outcome and word, in the block's decision order
	function automatic logic [34:0] expect_read(input logic g, input logic m);
		logic l1n, sr;
		logic [23:0] id;
		l1n = ns && lv == LEVEL1;
		sr = c[0] ? c[11 + g] : c[9 + g];
		id = g ? (o1 ? p1 : SPECIAL_1023) : o0 ? p0
			: s0 inside {SPECIAL_1020, SPECIAL_1021} ? s0 : SPECIAL_1023;
		if (w == IDENTIFIER_WIDTH_FIELD_16) id[23:16] = 8'h00;
		if (!m) return {OUT_NOT_MINE, READ_ZERO};
		if (lv == LEVEL0) return {OUT_UNDEF, READ_ZERO};
		if (l1n && c[3]) return {OUT_TRAP_L2, READ_ZERO};
		if (l1n && c[1 + g]) return {OUT_VIRTUAL, READ_ZERO};
		if (!c[3 + lv]) return {OUT_UNDEF, READ_ZERO};
		if (l1n && c[7 + g]) return {OUT_TRAP_L2, READ_ZERO};
		if (sr && c[0] && lv != LEVEL3) return {OUT_TRAP_L3, READ_ZERO};
		if (sr && !c[0] && (lv == LEVEL2 || lv == LEVEL3 && !mm || l1n))
			return {OUT_UNDEF, READ_ZERO};
		return {OUT_DATA, 8'h00, id};
	endfunction
	task automatic check(input string n, input logic [34:0] ex, input logic [34:0] got);
		samples_checked++;
		if (got !== ex) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", n, ex, got);
		end
	endtask
	task automatic test_done;
		if (q.size() != 0) fail_count++;
		$display("checked %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial forever #10 REF_CLK = ~REF_CLK;
	// Oldest queued answer is compared whenever the block answers
	always @(posedge REF_CLK) begin
		#2;
		if (RD_DONE === 1'b1) begin
			x = q.size() ? q.pop_front() : 'x;
			check("answer", x, {oc, dat});
		end
	end
	// Hang guard well above the expected run length
	always @(posedge REF_CLK) begin
		cyc++;
		if (cyc == 2000) begin
			fail_count++;
			test_done;
		end
	end
	// Reset, then random reads with gaps, runs and foreign encodings
	initial begin
		core_u.send(1'b0, 18'h0);
		void'($urandom(32'h3C53));
		repeat (8) @(posedge REF_CLK);
		#1 SRST = 0;
		repeat (600) begin
			@(posedge REF_CLK);
			#1 {c, w, lv, ns, mm, o0, o1, g, on} = $urandom;
			p0 = $urandom;
			p1 = $urandom;
			s0 = 24'h3FC + $urandom_range(3);
			ns |= lv == LEVEL2;
			e = {11'h78C, 1'b1, g, 5'h02} ^ ($urandom_range(7) ? 18'h0 : 18'h1 << $urandom_range(17));
			m = e[17:7] == 11'h78C && e[6] && e[4:0] == 5'h02;
			core_u.send(on, e);
			if (on) q.push_back(expect_read(e[5], m));
		end
		// Drop the request so the last read is not answered again
		@(posedge REF_CLK);
		#1 core_u.send(1'b0, 18'h0);
		repeat (3) @(posedge REF_CLK);
		test_done;
	end
endmodule
`default_nettype wire
